/* rspm_pkg.sv */
// rspm_pkg: constants and types for the relay switch operation-mode controller
// assumes: one system clock; supply monitors arrive as synchronous levels
package rspm_pkg;
	localparam int          RSPM_CHANNELS   = 8;
	localparam int          RSPM_CFG_W      = 8;
	localparam int          RSPM_BANK_DEPTH = 4;
	localparam logic [7:0]  RSPM_CH_RESET   = 8'h00;
	localparam logic [7:0]  RSPM_CFG_RESET  = 8'h00;
	localparam logic [1:0]  RSPM_ADDR_OUT   = 2'h0;
	typedef enum logic [1:0] {
		RSPM_SLEEP,
		RSPM_OPER,
		RSPM_LIMP
	} rspm_mode_t;
endpackage : rspm_pkg

/* rspm_bank.sv */
// rspm_bank: small register bank holding channel and control configuration
// assumes: clear has priority over write; read data registered
`timescale 1ns/1ps
module rspm_bank #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             clk_en,
	input  wire logic             clear,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [WIDTH-1:0] rd_q;
	logic [WIDTH-1:0] rd_d;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_comb begin
				if (clear) begin
					mem_d[gi] = '0;
				end else if (wr_en && wr_addr == AW'(gi)) begin
					mem_d[gi] = wr_data;
				end else begin
					mem_d[gi] = mem_q[gi];
				end
			end
			always_ff @(posedge clk_sys) begin
				if (clk_en) begin
					mem_q[gi] <= mem_d[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		rd_d = clear ? '0 : mem_q[rd_addr];
	end
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			rd_q <= rd_d;
		end
	end
	assign rd_data = rd_q;
endmodule // rspm_bank

/* rspm_ctrl.sv */
// rspm_ctrl: operation-mode controller of an eight-channel relay switch
// assumes: decoded serial commands arrive as one-cycle strobes; supply
// monitors and the limp home pin are synchronous levels
//
// Functional notes
// - battery start-up resets all registers except the serial output and enters sleep mode
// - wake command bit at one moves sleep into operation mode
// - standby command bit at one moves operation back to sleep
// - entering sleep clears register banks to reset contents
// - battery under-voltage resets the register banks
// - limp home input activates limp home regardless of serial commands
// - end of limp home enters sleep automatically
// - cranking down to 4 V keeps outputs and configuration unchanged
// - without logic supply, state holds until limp home, a battery start-up or under-voltage, or supply returns
// - shift register and serial output run on logic supply alone
`timescale 1ns/1ps
module rspm_ctrl
	import rspm_pkg::*;
#(
	parameter int CHANNELS = rspm_pkg::RSPM_CHANNELS,
	parameter int CFG_W    = rspm_pkg::RSPM_CFG_W
) (
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire logic                  battery_start,
	input  wire logic                  battery_uv,
	input  wire logic                  battery_crank,
	input  wire logic                  logic_supply_ok,
	input  wire logic                  limp_home_input,
	input  wire logic                  cmd_valid,
	input  wire logic                  wake_command_bit,
	input  wire logic                  standby_command_bit,
	input  wire logic                  cmd_wr_en,
	input  wire logic [1:0]            cmd_wr_addr,
	input  wire logic [CFG_W-1:0]      cmd_wr_data,
	input  wire logic [CHANNELS-1:0]   limp_pattern,
	input  wire logic                  serial_in,
	input  wire logic                  serial_sel,
	output logic                       serial_out,
	output logic      [CHANNELS-1:0]   channel_on,
	output rspm_pkg::rspm_mode_t       mode,
	output logic                       banks_cleared
);
	import rspm_pkg::*;

	rspm_mode_t          mode_q, mode_d;
	logic                clr_q, clr_d;
	logic [CHANNELS-1:0] ch_q, ch_d;
	logic                so_q, so_d;
	logic                bank_clear;
	logic                cmd_ok;
	logic [CFG_W-1:0]    bank_rd;

	// commands only count when the logic supply carries the serial port
	assign cmd_ok = cmd_valid && logic_supply_ok;

	always_comb begin
		mode_d = mode_q;
		if (battery_start || battery_uv) begin
			mode_d = RSPM_SLEEP;
		end else if (limp_home_input) begin
			mode_d = RSPM_LIMP;
		end else begin
			case (mode_q)
				RSPM_SLEEP: begin
					if (cmd_ok && wake_command_bit) begin
						mode_d = RSPM_OPER;
					end
				end
				RSPM_OPER: begin
					if (cmd_ok && standby_command_bit) begin
						mode_d = RSPM_SLEEP;
					end
				end
				RSPM_LIMP: begin
					mode_d = RSPM_SLEEP;
				end
				default: mode_d = RSPM_SLEEP;
			endcase
		end
	end

	// banks clear on supply reset and on every entry into sleep
	assign bank_clear = battery_start || battery_uv ||
		(mode_d == RSPM_SLEEP && mode_q != RSPM_SLEEP);

	always_comb begin
		clr_d = bank_clear;
		ch_d  = ch_q;
		if (bank_clear) begin
			ch_d = RSPM_CH_RESET;
		end else if (mode_q == RSPM_LIMP) begin
			ch_d = limp_pattern;
		end else if (mode_q == RSPM_OPER && !battery_crank) begin
			ch_d = CHANNELS'(bank_rd);
		end
		// cranking in operation, or sleep: channels just hold
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_q <= RSPM_SLEEP;
			clr_q  <= 1'b1;
			ch_q   <= RSPM_CH_RESET;
		end else if (clk_en) begin
			mode_q <= mode_d;
			clr_q  <= clr_d;
			ch_q   <= ch_d;
		end
	end

	// daisy-chain pass-through depends only on the logic supply and serial_sel
	always_comb begin
		so_d = so_q;
		if (logic_supply_ok && serial_sel) begin
			so_d = serial_in;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			so_q <= 1'b0;
		end else if (clk_en) begin
			so_q <= so_d;
		end
	end

	rspm_bank #(
		.WIDTH (CFG_W),
		.DEPTH (RSPM_BANK_DEPTH),
		.AW    (2)
	) u_bank (
		.clk_sys (clk_sys),
		.clk_en  (clk_en),
		.clear   (bank_clear || sys_rst),
		.wr_en   (cmd_ok && cmd_wr_en && mode_q == RSPM_OPER && !battery_crank),
		.wr_addr (cmd_wr_addr),
		.wr_data (cmd_wr_data),
		.rd_addr (RSPM_ADDR_OUT),
		.rd_data (bank_rd)
	);

	assign serial_out    = so_q;
	assign channel_on    = ch_q;
	assign mode          = mode_q;
	assign banks_cleared = clr_q;

	wake_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_SLEEP && cmd_valid && logic_supply_ok && wake_command_bit
		&& !battery_start && !battery_uv && !limp_home_input |=> mode_q == RSPM_OPER)
		else $error("wake command did not reach operation");
	standby_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_OPER && cmd_valid && logic_supply_ok
		&& standby_command_bit && !battery_start && !battery_uv && !limp_home_input
		|=> mode_q == RSPM_SLEEP)
		else $error("standby command did not reach sleep");
	start_sleep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_start |=> mode_q == RSPM_SLEEP && channel_on == RSPM_CH_RESET)
		else $error("battery start-up did not reset");
	uv_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_uv |=> banks_cleared)
		else $error("under-voltage did not clear banks");
	sleep_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && $changed(mode_q) && mode_q == RSPM_SLEEP |-> banks_cleared)
		else $error("sleep entry without bank clear");
	limp_enter_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && limp_home_input && !battery_start && !battery_uv |=> mode_q == RSPM_LIMP)
		else $error("limp home input ignored");
	limp_exit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_LIMP && !limp_home_input |=> mode_q == RSPM_SLEEP)
		else $error("limp home exit not to sleep");
	crank_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_crank && mode_q == RSPM_OPER && !battery_start && !battery_uv
		&& !limp_home_input && !(cmd_valid && logic_supply_ok && standby_command_bit)
		|=> $stable(channel_on))
		else $error("channels moved during cranking");
	no_supply_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !logic_supply_ok && !battery_start && !battery_uv && !limp_home_input
		&& mode_q != RSPM_LIMP |=> $stable(mode_q))
		else $error("mode moved without logic supply");
	pass_thru_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && logic_supply_ok && serial_sel |=> serial_out == $past(serial_in))
		else $error("daisy chain pass-through broken");

	// clock enable low must freeze every piece of state, reset aside
	freeze_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!clk_en
		|=> $stable(mode_q))
		else $error("mode moved while frozen");

	freeze_chan_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!clk_en
		|=> $stable(ch_q))
		else $error("channels moved while frozen");

	freeze_serial_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!clk_en
		|=> $stable(so_q))
		else $error("serial output moved while frozen");

	freeze_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!clk_en
		|=> $stable(clr_q))
		else $error("clear flag moved while frozen");

	mode_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_q inside {RSPM_SLEEP, RSPM_OPER, RSPM_LIMP})
		else $error("mode register left its legal codes");

	// supply events win over limp home and over any command
	start_bank_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_start
		|=> banks_cleared)
		else $error("battery start-up did not clear banks");

	start_wins_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_start && limp_home_input
		|=> mode_q == RSPM_SLEEP)
		else $error("battery start-up lost against limp home");

	uv_sleep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_uv
		|=> mode_q == RSPM_SLEEP)
		else $error("under-voltage did not force sleep");

	uv_chan_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_uv
		|=> channel_on == RSPM_CH_RESET)
		else $error("under-voltage left channels on");

	uv_wins_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_uv && cmd_valid && logic_supply_ok && wake_command_bit
		|=> mode_q == RSPM_SLEEP)
		else $error("wake command beat under-voltage");

	// the shift path ignores the battery side entirely
	start_serial_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_start && logic_supply_ok && serial_sel
		|=> serial_out == $past(serial_in))
		else $error("pass-through stopped on battery start-up");

	uv_serial_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_uv && logic_supply_ok && serial_sel
		|=> serial_out == $past(serial_in))
		else $error("pass-through stopped on under-voltage");

	serial_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !(logic_supply_ok && serial_sel)
		|=> $stable(serial_out))
		else $error("serial output moved while idle");

	// a missing logic supply refuses every command
	wake_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_SLEEP && !logic_supply_ok && !battery_start && !battery_uv
		&& !limp_home_input |=> mode_q == RSPM_SLEEP)
		else $error("sleep left without logic supply");

	stby_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_OPER && !logic_supply_ok && !battery_start && !battery_uv
		&& !limp_home_input |=> mode_q == RSPM_OPER)
		else $error("operation left without logic supply");

	nosup_limp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && !logic_supply_ok && limp_home_input && !battery_start && !battery_uv
		|=> mode_q == RSPM_LIMP)
		else $error("limp home blocked by missing logic supply");

	// mode only moves on its own command
	wake_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_SLEEP && !(cmd_valid && logic_supply_ok && wake_command_bit)
		&& !limp_home_input |=> mode_q == RSPM_SLEEP)
		else $error("sleep left without wake command");

	oper_stays_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_OPER && !(cmd_valid && logic_supply_ok && standby_command_bit)
		&& !battery_start && !battery_uv && !limp_home_input |=> mode_q == RSPM_OPER)
		else $error("operation left without standby command");

	// the clear flag marks the entries into sleep and the battery start-up and under-voltage events
	stby_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_OPER && cmd_valid && logic_supply_ok && standby_command_bit
		&& !limp_home_input |=> banks_cleared && channel_on == RSPM_CH_RESET)
		else $error("standby did not clear banks");

	sleep_chan_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_SLEEP && !limp_home_input
		|=> channel_on == RSPM_CH_RESET)
		else $error("channel on during sleep");

	sleep_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_SLEEP && !battery_start && !battery_uv
		|=> !banks_cleared)
		else $error("clear flag stuck during sleep");

	oper_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_OPER && !(cmd_valid && logic_supply_ok && standby_command_bit)
		&& !battery_start && !battery_uv |=> !banks_cleared)
		else $error("banks cleared during operation");

	limp_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_LIMP && !limp_home_input
		|=> banks_cleared)
		else $error("limp home exit did not clear banks");

	// limp home drives channels from its own pattern and ignores commands
	limp_chan_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_LIMP && limp_home_input && !battery_start && !battery_uv
		|=> channel_on == $past(limp_pattern))
		else $error("limp pattern not applied");

	limp_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && mode_q == RSPM_LIMP && limp_home_input && !battery_start && !battery_uv
		|=> mode_q == RSPM_LIMP)
		else $error("limp home left while pin high");

	// cranking must not knock the device out of operation
	crank_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clk_en && battery_crank && mode_q == RSPM_OPER && !battery_start && !battery_uv
		&& !limp_home_input && !(cmd_valid && logic_supply_ok && standby_command_bit)
		|=> mode_q == RSPM_OPER)
		else $error("cranking changed the mode");
endmodule // rspm_ctrl

/* rspm_host.sv */
// rspm_host: host side that issues decoded serial commands to the controller
// assumes: drives on the falling edge, the controller samples on the rising edge
`timescale 1ns/1ps
module rspm_host (
	input  wire logic       clk_sys,
	output logic            cmd_valid,
	output logic            wake_command_bit,
	output logic            standby_command_bit,
	output logic            cmd_wr_en,
	output logic      [1:0] cmd_wr_addr,
	output logic      [7:0] cmd_wr_data
);
	initial begin
		{cmd_valid, wake_command_bit, standby_command_bit, cmd_wr_en} = 4'h0;
		cmd_wr_addr = 2'h0;
		cmd_wr_data = 8'h00;
	end
	// op 0 wake, 1 standby, 2 write of channel word
	task automatic send(input logic [1:0] op, input logic [7:0] data);
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		wake_command_bit = (op == 2'h0);
		standby_command_bit = (op == 2'h1);
		cmd_wr_en = (op == 2'h2);
		cmd_wr_data = data;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// stale qualifiers are inverted so a design ignoring cmd_valid misbehaves
		{wake_command_bit, standby_command_bit, cmd_wr_en} = ~{wake_command_bit,
			standby_command_bit, cmd_wr_en};
		cmd_wr_data = ~data;
	endtask
endmodule // rspm_host

/* testbench.sv */
// testbench: scenario tasks for the operation-mode controller
// assumes: rspm_host drives commands; bench drives supplies and pins at negedge
`timescale 1ns/1ps
module testbench;
	import rspm_pkg::*;
	logic       clk_sys = 1'b0, sys_rst = 1'b1, battery_start = 1'b0, battery_uv = 1'b0;
	logic       battery_crank = 1'b0, logic_supply_ok = 1'b1, limp_home_input = 1'b0;
	logic       serial_in = 1'b0, serial_sel = 1'b1, serial_out, banks_cleared;
	logic       cmd_valid, wake_command_bit, standby_command_bit, cmd_wr_en;
	logic [1:0] cmd_wr_addr;
	logic [7:0] cmd_wr_data, channel_on, limp_pattern = 8'h3c;
	rspm_mode_t mode;
	int         err_total = 0, n_compared = 0, cyc = 0;

	rspm_host i_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
		.wake_command_bit(wake_command_bit), .standby_command_bit(standby_command_bit),
		.cmd_wr_en(cmd_wr_en), .cmd_wr_addr(cmd_wr_addr), .cmd_wr_data(cmd_wr_data));
	rspm_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
		.battery_start(battery_start), .battery_uv(battery_uv),
		.battery_crank(battery_crank), .logic_supply_ok(logic_supply_ok),
		.limp_home_input(limp_home_input), .cmd_valid(cmd_valid),
		.wake_command_bit(wake_command_bit), .standby_command_bit(standby_command_bit),
		.cmd_wr_en(cmd_wr_en), .cmd_wr_addr(cmd_wr_addr), .cmd_wr_data(cmd_wr_data),
		.limp_pattern(limp_pattern), .serial_in(serial_in), .serial_sel(serial_sel),
		.serial_out(serial_out), .channel_on(channel_on), .mode(mode),
		.banks_cleared(banks_cleared));

	initial forever #2 clk_sys = ~clk_sys;

	task automatic print_verdict;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic t_reset;
		chk(8'(mode), 8'(RSPM_SLEEP));
		chk(channel_on, 8'h00);
		chk({7'h00, banks_cleared}, 8'h01);
	endtask
	task automatic t_oper;
		i_host.send(2'h0, 8'h00);
		chk(8'(mode), 8'(RSPM_OPER));
		i_host.send(2'h2, 8'hff);
		i_host.send(2'h0, 8'h00);
		tick(2);
		chk(channel_on, 8'hff);
		chk(8'(mode), 8'(RSPM_OPER));
	endtask
	task automatic t_crank;
		battery_crank = 1'b1;
		i_host.send(2'h2, 8'h00);
		tick(3);
		chk(channel_on, 8'hff);
		battery_crank = 1'b0;
		logic_supply_ok = 1'b0;
		i_host.send(2'h1, 8'h00);
		chk(8'(mode), 8'(RSPM_OPER));
		i_host.send(2'h2, 8'h00);
		tick(3);
		chk(channel_on, 8'hff);
		logic_supply_ok = 1'b1;
	endtask
	task automatic t_standby;
		i_host.send(2'h1, 8'h00);
		chk(8'(mode), 8'(RSPM_SLEEP));
		chk(channel_on, 8'h00);
		chk({7'h00, banks_cleared}, 8'h01);
		i_host.send(2'h0, 8'h00);
		tick(3);
		chk(channel_on, 8'h00);
	endtask
	task automatic t_limp;
		limp_home_input = 1'b1;
		tick(2);
		chk(8'(mode), 8'(RSPM_LIMP));
		chk(channel_on, 8'h3c);
		limp_home_input = 1'b0;
		tick(3);
		chk(8'(mode), 8'(RSPM_SLEEP));
	endtask
	task automatic t_power;
		i_host.send(2'h0, 8'h00);
		i_host.send(2'h2, 8'h5a);
		tick(3);
		chk(channel_on, 8'h5a);
		battery_uv = 1'b1;
		tick(2);
		chk(channel_on, 8'h00);
		battery_uv = 1'b0;
		i_host.send(2'h0, 8'h00);
		i_host.send(2'h2, 8'ha5);
		tick(3);
		battery_start = 1'b1;
		tick(1);
		battery_start = 1'b0;
		tick(1);
		chk(8'(mode), 8'(RSPM_SLEEP));
		chk(channel_on, 8'h00);
	endtask
	task automatic t_serial;
		// battery absent while the shift path must still pass data
		battery_uv = 1'b1;
		for (int i = 0; i < 4; i++) begin
			serial_in = ~serial_in;
			tick(1);
			chk({7'h00, serial_out}, {7'h00, serial_in});
		end
		battery_uv = 1'b0;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		tick(12);
		sys_rst = 1'b0;
		t_reset();
		t_oper();
		t_crank();
		t_standby();
		t_limp();
		t_power();
		t_serial();
		print_verdict();
	end
endmodule // testbench
